// ---- hw/fis_pkg.sv ----
package fis_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] FIS_ADDR_OUT2_LATCH = 8'h39;
  localparam logic [7:0] FIS_ADDR_HEADSET_LATCH = 8'h3A;
  localparam logic [7:0] FIS_ADDR_THRESH_LATCH = 8'h3B;
  localparam logic [7:0] FIS_ADDR_CLOCK_LIVE = 8'h3C;
  localparam logic [7:0] FIS_ADDR_CHAN_LIVE = 8'h3D;
  localparam logic [7:0] FIS_RESET_VALUE = 8'h00;

  // ***************************************************************
  // field positions
  // ***************************************************************
  // output channel 2 latched register
  localparam int FIS_OUT2_POS_SHORT = 7;
  localparam int FIS_OUT2_NEG_SHORT = 6;
  localparam int FIS_OUT2_POS_DRIVER = 5;
  localparam int FIS_OUT2_NEG_DRIVER = 4;
  localparam int FIS_OUT2_REG_MASK = 1;
  localparam int FIS_OUT2_REG_SHORT = 0;
  // headset latched register
  localparam int FIS_HS_INSERT = 3;
  localparam int FIS_HS_REMOVE = 2;
  localparam int FIS_HS_HOOK = 1;
  // threshold and voice latched register
  localparam int FIS_TV_ABOVE = 7;
  localparam int FIS_TV_BELOW = 6;
  localparam int FIS_TV_VOICE_UP = 5;
  localparam int FIS_TV_VOICE_DOWN = 4;
  // live clock and lock register
  localparam int FIS_LIVE_CLOCK_ERR = 7;
  localparam int FIS_LIVE_PLL_LOCK = 6;
  // live channel summary register
  localparam int FIS_SUM_IN1 = 7;
  localparam int FIS_SUM_IN2 = 6;
  localparam int FIS_SUM_OUT1 = 5;
  localparam int FIS_SUM_OUT2 = 4;

  // number of asynchronous fault and event sources
  localparam int FIS_NUM_SOURCES = 17;

endpackage

// ---- hw/fis_fault_status.sv ----
// Contract
// - positive leg short of output 2 latches bit 7, cleared by reading
// - negative leg short of output 2 latches bit 6, cleared by reading
// - driver virtual-ground faults latch bit 5 (positive), bit 4 (negative)
// - bit 1 of output 2 register is read-write regulator short mask
// - regulator short latches bit 0 of output 2 register, read-cleared
// - headset insertion latches bit 3 of register 0x3A
// - headset removal latches bit 2 of register 0x3A
// - hook button press latches bit 1 of register 0x3A
// - analog input above upper threshold latches bit 7 of 0x3B
// - analog input below lower threshold latches bit 6 of 0x3B
// - voice activity power-up latches bit 5 of 0x3B
// - voice activity power-down latches bit 4 of 0x3B
// - bit 7 of 0x3C shows live clock error, not latched
// - bit 6 of 0x3C shows live lock condition
// - bit 7 of 0x3D is high while input channel 1 faults
// - bit 6 of 0x3D is high while input channel 2 faults
// - bit 5 of 0x3D is high while output channel 1 faults
// - bit 4 of 0x3D is high while output channel 2 faults
// - reserved bits read zero; host writes only zero into them
// - all status registers reset to zero
module fis_fault_status
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic secondOutputPositiveLegShort,
  input wire logic secondOutputNegativeLegShort,
  input wire logic positiveDriverVgFault,
  input wire logic negativeDriverVgFault,
  input wire logic analogRegulatorShort,
  input wire logic headsetInsert,
  input wire logic headsetRemove,
  input wire logic headsetHook,
  input wire logic generalAnalogInputAbove,
  input wire logic generalAnalogInputBelow,
  input wire logic voiceActivityDetectorUp,
  input wire logic voiceActivityDetectorDown,
  input wire logic clockError,
  input wire logic pllLock,
  input wire logic inputCh1Fault,
  input wire logic inputCh2Fault,
  input wire logic outputCh1Fault
);
  import fis_pkg::*;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // set wins over the read clear so an event in the read cycle survives
  function automatic logic [7:0] fis_latch_next(
    input logic [7:0] cur,
    input logic [7:0] setBits,
    input logic clr
  );
    fis_latch_next = (clr ? 8'h00 : cur) | setBits;
  endfunction

  // ***************************************************************
  // source synchroniser
  // ***************************************************************
  logic [FIS_NUM_SOURCES-1:0] srcAsync;
  logic [FIS_NUM_SOURCES-1:0] srcMeta_r;
  logic [FIS_NUM_SOURCES-1:0] srcSync_r;
  logic in1S, in2S, out1S, clkErrS, pllS;
  logic aboveS, belowS, voiceUpS, voiceDownS;
  logic insS, remS, hookS;
  logic posShortS, negShortS, posDrvS, negDrvS, regShortS;

  // all sources come from analog detectors, so they are asynchronous
  assign srcAsync = {inputCh1Fault, inputCh2Fault, outputCh1Fault,
                     clockError, pllLock,
                     generalAnalogInputAbove, generalAnalogInputBelow,
                     voiceActivityDetectorUp, voiceActivityDetectorDown,
                     headsetInsert, headsetRemove, headsetHook,
                     secondOutputPositiveLegShort,
                     secondOutputNegativeLegShort,
                     positiveDriverVgFault, negativeDriverVgFault,
                     analogRegulatorShort};

  // two stages; only the second stage is read by logic
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      srcMeta_r <= '0;
      srcSync_r <= '0;
    end
    else
    begin
      srcMeta_r <= srcAsync;
      srcSync_r <= srcMeta_r;
    end
  end

  assign {in1S, in2S, out1S, clkErrS, pllS,
          aboveS, belowS, voiceUpS, voiceDownS,
          insS, remS, hookS,
          posShortS, negShortS, posDrvS, negDrvS, regShortS} = srcSync_r;

  // ***************************************************************
  // decode
  // ***************************************************************
  logic rdOut2, rdHeadset, rdThresh, wrOut2;
  logic [7:0] out2Set, headsetSet, threshSet;

  assign rdOut2 = regRdEn && (regAddr == FIS_ADDR_OUT2_LATCH);
  assign rdHeadset = regRdEn && (regAddr == FIS_ADDR_HEADSET_LATCH);
  assign rdThresh = regRdEn && (regAddr == FIS_ADDR_THRESH_LATCH);
  assign wrOut2 = regWrEn && (regAddr == FIS_ADDR_OUT2_LATCH);

  // ***************************************************************
  // latched status
  // ***************************************************************
  logic [7:0] out2Latch_r, out2Latch_nxt;
  logic [7:0] headsetLatch_r, headsetLatch_nxt;
  logic [7:0] threshLatch_r, threshLatch_nxt;
  logic regMask_r, regMask_nxt;

  // leg shorts, driver faults; masked regulator short never latches
  assign out2Set = {posShortS, negShortS, posDrvS, negDrvS, 3'b000,
                    regShortS & ~regMask_r};
  assign headsetSet = {4'h0, insS, remS, hookS, 1'b0};
  assign threshSet = {aboveS, belowS, voiceUpS, voiceDownS,
                      4'h0};

  // read-to-clear on each latched register
  assign out2Latch_nxt = fis_latch_next(out2Latch_r, out2Set,
                                        rdOut2);
  assign headsetLatch_nxt = fis_latch_next(headsetLatch_r, headsetSet,
                                           rdHeadset);
  assign threshLatch_nxt = fis_latch_next(threshLatch_r, threshSet,
                                          rdThresh);
  // only the mask bit takes written data
  assign regMask_nxt = wrOut2 ? regWrData[FIS_OUT2_REG_MASK]
                              : regMask_r;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      out2Latch_r <= FIS_RESET_VALUE;
      headsetLatch_r <= FIS_RESET_VALUE;
      threshLatch_r <= FIS_RESET_VALUE;
      regMask_r <= 1'b0;
    end
    else
    begin
      out2Latch_r <= out2Latch_nxt;
      headsetLatch_r <= headsetLatch_nxt;
      threshLatch_r <= threshLatch_nxt;
      regMask_r <= regMask_nxt;
    end
  end

  // ***************************************************************
  // live status and read mux
  // ***************************************************************
  logic out2Any;
  logic [7:0] out2View, clockLive, chanLive, rdMux;
  logic [7:0] regRdData_r;

  // summary uses raw regulator short: the mask hides latching only
  assign out2Any = posShortS | negShortS | posDrvS | negDrvS
                   | regShortS;
  assign out2View = out2Latch_r
                    | {6'h00, regMask_r, 1'b0};
  assign clockLive = {clkErrS, pllS, 6'h00};
  assign chanLive = {in1S, in2S, out1S, out2Any,
                     4'h0};
  // unmapped addresses read as zero
  assign rdMux = (regAddr == FIS_ADDR_OUT2_LATCH) ? out2View :
                 (regAddr == FIS_ADDR_HEADSET_LATCH) ? headsetLatch_r :
                 (regAddr == FIS_ADDR_THRESH_LATCH) ? threshLatch_r :
                 (regAddr == FIS_ADDR_CLOCK_LIVE) ? clockLive :
                 (regAddr == FIS_ADDR_CHAN_LIVE) ? chanLive :
                 FIS_RESET_VALUE;

  // read data is captured before the clear takes effect
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      regRdData_r <= FIS_RESET_VALUE;
    else if (regRdEn)
      regRdData_r <= rdMux;
  end

  assign regRdData = regRdData_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence seqReadOut2;
    rdOut2 && !posShortS;
  endsequence

  sequence seqPosShortCleared;
    !out2Latch_r[FIS_OUT2_POS_SHORT];
  endsequence

  // state seen at the first edge after release; the mask must go too
  sequence seqResetState;
    out2Latch_r == FIS_RESET_VALUE && headsetLatch_r == FIS_RESET_VALUE
      && threshLatch_r == FIS_RESET_VALUE && !regMask_r
      && regRdData == FIS_RESET_VALUE;
  endsequence

  AST_RESET_STATE: assert property (
    $rose(resetn) |-> seqResetState)
    else $error("state not cleared by reset");

  AST_OUT2_POS_SHORT: assert property (
    posShortS |=> out2Latch_r[FIS_OUT2_POS_SHORT])
    else $error("positive leg short not latched");

  AST_OUT2_NEG_SHORT: assert property (
    $rose(negShortS) |=> out2Latch_r[FIS_OUT2_NEG_SHORT] ##1
      (out2Latch_r[FIS_OUT2_NEG_SHORT] || $past(rdOut2)))
    else $error("negative leg short not latched or lost");

  // one check per driver, since the faults rarely come together
  AST_OUT2_POS_DRIVER: assert property (
    posDrvS |=> out2Latch_r[FIS_OUT2_POS_DRIVER])
    else $error("positive driver fault not latched");

  AST_OUT2_NEG_DRIVER: assert property (
    negDrvS |=> out2Latch_r[FIS_OUT2_NEG_DRIVER])
    else $error("negative driver fault not latched");

  AST_REG_MASK_WRITE: assert property (
    wrOut2 |=> regMask_r == $past(regWrData[FIS_OUT2_REG_MASK]))
    else $error("regulator mask write not stored");

  AST_REG_SHORT: assert property (
    (regShortS && !regMask_r) |=> out2Latch_r[FIS_OUT2_REG_SHORT])
    else $error("regulator short not latched");

  // a masked short must never reach the latch
  AST_REG_SHORT_MASKED: assert property (
    (regMask_r && !out2Latch_r[FIS_OUT2_REG_SHORT]) |=>
      !out2Latch_r[FIS_OUT2_REG_SHORT])
    else $error("masked regulator short latched");

  AST_HS_INSERT: assert property (
    insS |=> headsetLatch_r[FIS_HS_INSERT])
    else $error("headset insertion not latched");

  AST_HS_REMOVE: assert property (
    remS |=> headsetLatch_r[FIS_HS_REMOVE])
    else $error("headset removal not latched");

  AST_HS_HOOK: assert property (
    hookS |=> headsetLatch_r[FIS_HS_HOOK])
    else $error("hook press not latched");

  AST_TV_ABOVE: assert property (
    aboveS |=> threshLatch_r[FIS_TV_ABOVE])
    else $error("upper threshold event not latched");

  AST_TV_BELOW: assert property (
    belowS |=> threshLatch_r[FIS_TV_BELOW])
    else $error("lower threshold event not latched");

  AST_TV_VOICE_UP: assert property (
    voiceUpS |=> threshLatch_r[FIS_TV_VOICE_UP])
    else $error("voice power-up event not latched");

  AST_TV_VOICE_DOWN: assert property (
    voiceDownS |=> threshLatch_r[FIS_TV_VOICE_DOWN])
    else $error("voice power-down event not latched");

  AST_CLOCK_LIVE_READ: assert property (
    (regRdEn && regAddr == FIS_ADDR_CLOCK_LIVE) |=>
      regRdData == {$past(clkErrS), $past(pllS), 6'h00})
    else $error("live clock flags read wrong");

  AST_CHAN_LIVE_READ: assert property (
    (regRdEn && regAddr == FIS_ADDR_CHAN_LIVE) |=>
      regRdData[7:4] == $past({in1S, in2S, out1S,
        posShortS | negShortS | posDrvS | negDrvS | regShortS}))
    else $error("channel summary read wrong");

  AST_RESERVED_ZERO: assert property (
    (regRdEn && regAddr == FIS_ADDR_OUT2_LATCH) |=>
      regRdData[3:2] == 2'b00)
    else $error("reserved bits not zero");

  // reserved latch bits have no set source, so they stay at zero
  AST_RESERVED_LATCHED: assert property (
    headsetLatch_r[7:4] == 4'h0 && !headsetLatch_r[0]
      && threshLatch_r[3:0] == 4'h0 && out2Latch_r[3:1] == 3'b000)
    else $error("reserved latch bit set");

  AST_READ_CLEARS: assert property (
    seqReadOut2 |=> seqPosShortCleared)
    else $error("read did not clear latched bit");

  AST_LATCH_HOLDS: assert property (
    (headsetLatch_r[FIS_HS_INSERT] && !rdHeadset) |=>
      headsetLatch_r[FIS_HS_INSERT])
    else $error("latched bit dropped without read");

endmodule

// ---- tb/fis_fault_status_tb.sv ----
module fis_fault_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fis_pkg::*;

  // ***************************************************************
  // stimulus and bookkeeping
  // ***************************************************************
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic [16:0] srcVec = 17'h00000;
  int mismatches = 0;
  int testsRun = 0;
  // bit position of each source, in srcVec order
  int posTab [17] = '{7, 6, 5, 4, 0, 3, 2, 1, 7, 6, 5, 4, 7, 6, 7, 6, 5};

  // ***************************************************************
  // design under test
  // ***************************************************************
  fis_fault_status DUT
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .secondOutputPositiveLegShort(srcVec[0]),
    .secondOutputNegativeLegShort(srcVec[1]),
    .positiveDriverVgFault(srcVec[2]),
    .negativeDriverVgFault(srcVec[3]),
    .analogRegulatorShort(srcVec[4]),
    .headsetInsert(srcVec[5]),
    .headsetRemove(srcVec[6]),
    .headsetHook(srcVec[7]),
    .generalAnalogInputAbove(srcVec[8]),
    .generalAnalogInputBelow(srcVec[9]),
    .voiceActivityDetectorUp(srcVec[10]),
    .voiceActivityDetectorDown(srcVec[11]),
    .clockError(srcVec[12]),
    .pllLock(srcVec[13]),
    .inputCh1Fault(srcVec[14]),
    .inputCh2Fault(srcVec[15]),
    .outputCh1Fault(srcVec[16])
  );

  // free-running 100 MHz clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  // register that holds a given source
  function automatic logic [7:0] addrOf(input int i);
    if (i < 5) return FIS_ADDR_OUT2_LATCH;
    if (i < 8) return FIS_ADDR_HEADSET_LATCH;
    if (i < 12) return FIS_ADDR_THRESH_LATCH;
    if (i < 14) return FIS_ADDR_CLOCK_LIVE;
    return FIS_ADDR_CHAN_LIVE;
  endfunction

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one read strobe, data sampled just after the taking edge
  task automatic rdChk(input logic [7:0] a, input logic [7:0] expv);
    logic [7:0] got;
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1;
    got = regRdData;
    testsRun++;
    if (got !== expv)
    begin
      $display("[FAIL] reg %h expected %h seen %h", a, expv, got);
      mismatches++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask

  // four edges cover the two-flop sync plus the latch stage
  task automatic setSrc(input int i, input logic v);
    @(posedge clk_sys);
    srcVec[i] <= v;
    repeat (4) @(posedge clk_sys);
  endtask

  // hang guard: the whole sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    print_verdict();
  end

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial
  begin
    logic [7:0] bitv;
    logic [7:0] latv;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values, then an unmapped read and an ignored write
    for (int a = 8'h39; a <= 8'h3D; a++)
      rdChk(8'(a), FIS_RESET_VALUE);
    rdChk(8'h50, 8'h00);
    // status bits only: reserved fields are written with zero
    wr(FIS_ADDR_HEADSET_LATCH, 8'h0E);
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h00);
    // every source: latch after release, zero for 0x3C/0x3D sources; live view while held only for output 2 and 0x3C/0x3D sources
    for (int i = 0; i < FIS_NUM_SOURCES; i++)
    begin
      bitv = 8'h01 << posTab[i];
      latv = (i >= 12) ? 8'h00 : bitv;
      setSrc(i, 1'b1);
      if (i >= 12) rdChk(addrOf(i), bitv);
      if (i < 5) rdChk(FIS_ADDR_CHAN_LIVE, 8'h10);
      setSrc(i, 1'b0);
      rdChk(addrOf(i), latv);
      rdChk(addrOf(i), 8'h00);
    end
    // mask blocks the latch but not the live summary
    wr(FIS_ADDR_OUT2_LATCH, 8'h02);
    rdChk(FIS_ADDR_OUT2_LATCH, 8'h02);
    setSrc(4, 1'b1);
    rdChk(FIS_ADDR_CHAN_LIVE, 8'h10);
    setSrc(4, 1'b0);
    rdChk(FIS_ADDR_OUT2_LATCH, 8'h02);
    wr(FIS_ADDR_OUT2_LATCH, 8'h00);
    setSrc(4, 1'b1);
    setSrc(4, 1'b0);
    rdChk(FIS_ADDR_OUT2_LATCH, 8'h01);
    // a read while the condition persists must not clear it
    setSrc(5, 1'b1);
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h08);
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h08);
    setSrc(5, 1'b0);
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h08);
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h00);
    // mid-run reset wipes a pending latch and the mask
    wr(FIS_ADDR_OUT2_LATCH, 8'h02);
    setSrc(7, 1'b1);
    setSrc(7, 1'b0);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdChk(FIS_ADDR_HEADSET_LATCH, 8'h00);
    rdChk(FIS_ADDR_OUT2_LATCH, 8'h00);
    print_verdict();
  end
endmodule
